// ===== rtl/fcs_pkg.sv
// Package for the flash command status block: map, fields, carriers
//
// Notes on behaviour
// - Command-complete flag, bit 7, is high when idle and low while running.
// - Writing one to command-complete launches the loaded command and clears the flag.
// - After launch, flag stays low until completion or a violation, then sets.
// - Access-error flag, bit 5, sets on sequence violation or illegal command.
// - While access-error is set, writing one to command-complete launches nothing.
// - Access-error clears only by writing one; writing zero leaves it.
// - Protection-violation flag, bit 4, sets on program or erase of protected area.
// - Protection-violation clears only by writing one; zero has no effect.
// - While protection-violation is set, no launch and no new write sequence.
// - Busy flag, bit 3, is one while the controller runs a command.
// - Completion-status field sets bits on errors in a command or reset sequence.
// - A double bit fault in the reset sequence shows in the completion-status field.
// - Bits 6 and 2 of the status register are read-only zero.
// - With the completion interrupt enable set, interrupt while command-complete is high.
`default_nettype none

package fcs_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] FCS_STATUS_IDX = 16'h3026;
	localparam logic [15:0] FCS_CONFIG_IDX = 16'h3024;
	localparam logic [15:0] FCS_CMDSEQ_IDX = 16'h3030;
	localparam logic [15:0] FCS_EVT_STAT_IDX = 16'h3031;
	localparam logic [15:0] FCS_EVT_CLR_IDX = 16'h3032;
	localparam logic [15:0] FCS_EVT_EN_IDX = 16'h3033;
	localparam logic [15:0] FCS_STATUS_ADDR = FCS_STATUS_IDX << 2;
	localparam logic [15:0] FCS_CONFIG_ADDR = FCS_CONFIG_IDX << 2;
	localparam logic [15:0] FCS_CMDSEQ_ADDR = FCS_CMDSEQ_IDX << 2;
	localparam logic [15:0] FCS_EVT_STAT_ADDR = FCS_EVT_STAT_IDX << 2;
	localparam logic [15:0] FCS_EVT_CLR_ADDR = FCS_EVT_CLR_IDX << 2;
	localparam logic [15:0] FCS_EVT_EN_ADDR = FCS_EVT_EN_IDX << 2;

	// Status register fields
	localparam int FCS_CMD_DONE_BIT = 7;
	localparam int FCS_ACC_ERR_BIT = 5;
	localparam int FCS_PVIOL_BIT = 4;
	localparam int FCS_BUSY_BIT = 3;
	localparam int FCS_COMP_STAT_LSB = 0;
	localparam int FCS_COMP_STAT_W = 2;

	// Config register fields
	localparam int FCS_DONE_IE_BIT = 7;

	// Command sequence register fields
	localparam int FCS_SEQ_LOAD_BIT = 0;

	// Event register bit positions
	localparam int FCS_EVT_DONE = 0;
	localparam int FCS_EVT_ACC_ERR = 1;
	localparam int FCS_EVT_PVIOL = 2;
	localparam int FCS_EVT_MGERR = 3;
	localparam int FCS_EVT_W = 4;

	// Reset values
	localparam logic FCS_DONE_IE_RST = 1'b0;
	localparam logic [FCS_COMP_STAT_W-1:0] FCS_COMP_STAT_RST = 2'h0;
	localparam logic [FCS_COMP_STAT_W-1:0] FCS_COMP_STAT_DBL = 2'h2;
	localparam logic [FCS_EVT_W-1:0] FCS_EVT_EN_RST = 4'h0;

	typedef enum logic [1:0] {
		FCS_ST_IDLE = 2'b01,
		FCS_ST_RUN = 2'b10
	} fcs_state_e;

	// From the memory controller, same clock
	typedef struct packed {
		logic busy;
		logic done;
		logic cmd_err;
		logic prot_err;
		logic [FCS_COMP_STAT_W-1:0] comp_stat;
	} fcs_ctl_in_s;

	// To the memory controller
	typedef struct packed {
		logic launch;
		logic seq_open;
	} fcs_ctl_out_s;

endpackage : fcs_pkg

`default_nettype wire

// ===== rtl/fcs_sticky.sv
// Sticky flags, set by hardware and cleared by writing one
`default_nettype none

module fcs_sticky #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Set and clear
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// Flags
	output logic [W-1:0] q
);

	// Set wins, so an event in the clearing cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= set | (q & ~clr);
		end
	end

endmodule : fcs_sticky

`default_nettype wire

// ===== rtl/fcs_top.sv
// Flash command status register logic with APB slave and interrupt
//
// Our own choice: the APB register port.
`default_nettype none

module fcs_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory controller
	input wire fcs_pkg::fcs_ctl_in_s ctl_in,
	input wire logic reset_dbl_fault,
	output fcs_pkg::fcs_ctl_out_s ctl_out,
	// Interrupt
	output logic irq
);
	import fcs_pkg::*;

	fcs_state_e state;
	fcs_state_e next_state;
	logic access_error_flag;
	logic protect_violation_flag;
	logic controller_busy_flag;
	logic [FCS_COMP_STAT_W-1:0] completion_status_field;
	logic cmd_complete_irq_enable;
	logic cmd_loaded;
	logic [FCS_EVT_W-1:0] evt_stat;
	logic [FCS_EVT_W-1:0] evt_en;
	logic [FCS_EVT_W-1:0] evt_set;
	logic [FCS_EVT_W-1:0] evt_clr;
	logic reset_seq_done;
	logic cmd_complete_flag;

	// Bus decode
	logic setup;
	logic wr_en;
	logic mapped;
	logic wr_status;
	logic wr_config;
	logic wr_cmdseq;
	logic wr_evt_clr;
	logic wr_evt_en;
	logic [31:0] next_prdata;

	// Launch and sequence decisions
	logic launch_try;
	logic launch_ok;
	logic launch_bad;
	logic seq_try;
	logic seq_ok;
	logic seq_bad;
	logic finish;
	logic acc_err_set;
	logic acc_err_clr;
	logic pviol_set;
	logic pviol_clr;

	assign setup = psel & ~penable;
	// Writes land at the edge where the master samples pready high
	assign wr_en = psel & penable & pready & pwrite & ~pslverr;
	assign wr_status = wr_en & (paddr == FCS_STATUS_ADDR);
	assign wr_config = wr_en & (paddr == FCS_CONFIG_ADDR);
	assign wr_cmdseq = wr_en & (paddr == FCS_CMDSEQ_ADDR);
	assign wr_evt_clr = wr_en & (paddr == FCS_EVT_CLR_ADDR);
	assign wr_evt_en = wr_en & (paddr == FCS_EVT_EN_ADDR);

	always_comb begin
		mapped = 1'b1;
		unique case (paddr)
			FCS_STATUS_ADDR, FCS_CONFIG_ADDR, FCS_CMDSEQ_ADDR: mapped = 1'b1;
			FCS_EVT_STAT_ADDR, FCS_EVT_CLR_ADDR, FCS_EVT_EN_ADDR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign cmd_complete_flag = (state == FCS_ST_IDLE);

	// Launch attempt by writing one to the complete flag
	assign launch_try = wr_status & pwdata[FCS_CMD_DONE_BIT];
	// Errors block the launch entirely
	assign launch_ok = launch_try & cmd_complete_flag & cmd_loaded
		& ~access_error_flag & ~protect_violation_flag;
	// Launching with no loaded command breaks the sequence
	assign launch_bad = launch_try & cmd_complete_flag & ~cmd_loaded
		& ~access_error_flag & ~protect_violation_flag;

	// A new write sequence is refused under protection violation
	assign seq_try = wr_cmdseq & pwdata[FCS_SEQ_LOAD_BIT];
	assign seq_ok = seq_try & cmd_complete_flag & ~protect_violation_flag;
	// Loading while a command runs violates the sequence
	assign seq_bad = seq_try & ~cmd_complete_flag;

	assign finish = (state == FCS_ST_RUN) & (ctl_in.done | ctl_in.cmd_err | ctl_in.prot_err);

	assign acc_err_set = launch_bad | seq_bad
		| ((state == FCS_ST_RUN) & ctl_in.cmd_err);
	assign acc_err_clr = wr_status & pwdata[FCS_ACC_ERR_BIT];
	assign pviol_set = (state == FCS_ST_RUN) & ctl_in.prot_err;
	assign pviol_clr = wr_status & pwdata[FCS_PVIOL_BIT];

	fcs_sticky #(
		.W(1)
	) u_acc_err (
		.pclk(pclk),
		.presetn(presetn),
		.set(acc_err_set),
		.clr(acc_err_clr),
		.q(access_error_flag)
	);

	fcs_sticky #(
		.W(1)
	) u_pviol (
		.pclk(pclk),
		.presetn(presetn),
		.set(pviol_set),
		.clr(pviol_clr),
		.q(protect_violation_flag)
	);

	// Command state
	always_comb begin
		next_state = state;
		unique case (state)
			FCS_ST_IDLE: begin
				if (launch_ok) begin
					next_state = FCS_ST_RUN;
				end
			end
			FCS_ST_RUN: begin
				if (finish) begin
					next_state = FCS_ST_IDLE;
				end
			end
			default: next_state = FCS_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= FCS_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Loaded command, consumed by its launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_loaded <= 1'b0;
		end else if (launch_ok) begin
			cmd_loaded <= 1'b0;
		end else if (seq_ok) begin
			cmd_loaded <= 1'b1;
		end
	end

	// Busy mirrors the controller only while a command is running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			controller_busy_flag <= 1'b0;
		end else begin
			controller_busy_flag <= (next_state == FCS_ST_RUN) & ctl_in.busy;
		end
	end

	// Completion status; the strap is caught after release, not in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			completion_status_field <= FCS_COMP_STAT_RST;
			reset_seq_done <= 1'b0;
		end else begin
			reset_seq_done <= 1'b1;
			if (!reset_seq_done) begin
				if (reset_dbl_fault) begin
					completion_status_field <= FCS_COMP_STAT_DBL;
				end
			end else if (launch_ok) begin
				completion_status_field <= FCS_COMP_STAT_RST;
			end else if ((state == FCS_ST_RUN) & ctl_in.done) begin
				completion_status_field <= completion_status_field | ctl_in.comp_stat;
			end
		end
	end

	// Configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_complete_irq_enable <= FCS_DONE_IE_RST;
		end else if (wr_config) begin
			cmd_complete_irq_enable <= pwdata[FCS_DONE_IE_BIT];
		end
	end

	// Event enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_en <= FCS_EVT_EN_RST;
		end else if (wr_evt_en) begin
			evt_en <= pwdata[FCS_EVT_W-1:0];
		end
	end

	// Event status, sticky until written one in the clear register
	always_comb begin
		evt_set = '0;
		evt_set[FCS_EVT_DONE] = finish;
		evt_set[FCS_EVT_ACC_ERR] = acc_err_set;
		evt_set[FCS_EVT_PVIOL] = pviol_set;
		evt_set[FCS_EVT_MGERR] = (state == FCS_ST_RUN) & ctl_in.done & (|ctl_in.comp_stat);
	end

	assign evt_clr = wr_evt_clr ? pwdata[FCS_EVT_W-1:0] : '0;

	fcs_sticky #(
		.W(FCS_EVT_W)
	) u_evt (
		.pclk(pclk),
		.presetn(presetn),
		.set(evt_set),
		.clr(evt_clr),
		.q(evt_stat)
	);

	// Level interrupt; registered, so event terms lag by one edge, but the complete term uses next_state and rises with the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (cmd_complete_irq_enable & (next_state == FCS_ST_IDLE))
				| (|(evt_stat & evt_en));
		end
	end

	// Controller strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_out <= '0;
		end else begin
			ctl_out.launch <= launch_ok;
			ctl_out.seq_open <= seq_ok;
		end
	end

	// Read data mux
	always_comb begin
		next_prdata = 32'h0;
		unique case (paddr)
			FCS_STATUS_ADDR: begin
				// Bits 6 and 2 stay zero from the default above
				next_prdata[FCS_CMD_DONE_BIT] = cmd_complete_flag;
				next_prdata[FCS_ACC_ERR_BIT] = access_error_flag;
				next_prdata[FCS_PVIOL_BIT] = protect_violation_flag;
				next_prdata[FCS_BUSY_BIT] = controller_busy_flag;
				next_prdata[FCS_COMP_STAT_LSB +: FCS_COMP_STAT_W] = completion_status_field;
			end
			FCS_CONFIG_ADDR: next_prdata[FCS_DONE_IE_BIT] = cmd_complete_irq_enable;
			FCS_CMDSEQ_ADDR: next_prdata[FCS_SEQ_LOAD_BIT] = cmd_loaded;
			FCS_EVT_STAT_ADDR: next_prdata[FCS_EVT_W-1:0] = evt_stat;
			FCS_EVT_EN_ADDR: next_prdata[FCS_EVT_W-1:0] = evt_en;
			default: next_prdata = 32'h0;
		endcase
	end

	// One access cycle: pready rises in the access phase, then drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			if (setup & ~pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

endmodule : fcs_top

`default_nettype wire

// ===== sim/fcs_top_asserts.sv
// Port assertions for the flash command status block
`default_nettype none

module fcs_top_asserts
	import fcs_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Controller
	input wire fcs_pkg::fcs_ctl_in_s ctl_in,
	input wire fcs_pkg::fcs_ctl_out_s ctl_out
);
	logic run;
	logic lw1;
	logic lw2;
	logic map_q;
	logic seq_w;
	logic st_rd;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign st_rd = pready && !pwrite && paddr == FCS_STATUS_ADDR;
	// Run window from launch pulse to end pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run <= 1'b0;
			lw1 <= 1'b0;
			lw2 <= 1'b0;
			map_q <= 1'b0;
			seq_w <= 1'b0;
		end else begin
			lw1 <= psel && penable && pready && pwrite && paddr == FCS_STATUS_ADDR && pwdata[7];
			lw2 <= lw1;
			seq_w <= psel && penable && pready && pwrite && paddr == FCS_CMDSEQ_ADDR && pwdata[0];
			map_q <= paddr inside {FCS_STATUS_ADDR, FCS_CONFIG_ADDR, FCS_CMDSEQ_ADDR,
				FCS_EVT_STAT_ADDR, FCS_EVT_CLR_ADDR, FCS_EVT_EN_ADDR};
			if (ctl_out.launch)
				run <= 1'b1;
			else if (ctl_in.done || ctl_in.cmd_err || ctl_in.prot_err)
				run <= 1'b0;
		end
	end
	a_status_rsvd: assert property (st_rd |-> !prdata[6] && !prdata[2])
		else $error("reserved status bit set");
	a_launch_cause: assert property (ctl_out.launch |-> lw1 || lw2)
		else $error("launch without status write");
	a_busy_not_done: assert property (st_rd && prdata[3] |-> !prdata[7])
		else $error("busy with command complete");
	a_cmd_complete_flag_low_run: assert property (st_rd && run && $past(run) |-> !prdata[7])
		else $error("command complete while running");
	a_single_launch: assert property (run |-> !ctl_out.launch)
		else $error("second launch while running");
	a_mg_clear_run: assert property (st_rd && run && $past(run) |-> prdata[1:0] == 2'h0)
		else $error("status field not cleared at launch");
	a_access_ready: assert property (psel && !penable |=> pready && (pslverr == !map_q))
		else $error("access phase answer wrong");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	a_seq_cause: assert property (ctl_out.seq_open |-> seq_w)
		else $error("load pulse without sequence write");
endmodule : fcs_top_asserts

bind fcs_top fcs_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ctl_in(ctl_in), .ctl_out(ctl_out));

`default_nettype wire

// ===== sim/fcs_tb_top.sv
// Self-checking bench for the flash command status block
`default_nettype none

module fcs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fcs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic reset_dbl_fault = 1'b0;
	logic irq;
	fcs_ctl_in_s ctl_in = '0;
	fcs_ctl_out_s ctl_out;
	logic [32:0] exp_q[$];
	logic [1:0] mg;
	int checks = 0;
	int n_errors = 0;
	logic [32:0] n_launch = '0;
	logic [32:0] n_seq = '0;
	always #50 pclk = ~pclk;
	fcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ctl_in(ctl_in), .reset_dbl_fault(reset_dbl_fault),
		.ctl_out(ctl_out), .irq(irq));
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	// Master waits on pready; only the watchdog ends a hang
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	task automatic pulse(input logic [5:0] v);
		@(posedge pclk);
		ctl_in <= v;
		@(posedge pclk);
		ctl_in <= '0;
	endtask : pulse
	// Fault level must stand at the first edge after release
	task automatic rst(input logic dbl);
		presetn <= 1'b0;
		reset_dbl_fault <= dbl;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : rst
	// Read results compared in order of issue
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			chk({pslverr, prdata}, exp_q.pop_front());
		if (ctl_out.launch === 1'b1)
			n_launch++;
		if (ctl_out.seq_open === 1'b1)
			n_seq++;
	end
	initial begin
		#300000;
		n_errors++;
		conclude();
	end
	initial begin
		void'($urandom(35781));
		rst(1'b1);
		rd(FCS_STATUS_ADDR, 33'h82);
		rst(1'b0);
		rd(FCS_STATUS_ADDR, 33'h80);
		rd(FCS_CONFIG_ADDR, 33'h0);
		rd(16'h0000, 33'h100000000);
		wr(FCS_STATUS_ADDR, 32'h80);
		rd(FCS_STATUS_ADDR, 33'ha0);
		wr(FCS_CMDSEQ_ADDR, 32'h1);
		rd(FCS_CMDSEQ_ADDR, 33'h1);
		wr(FCS_STATUS_ADDR, 32'h80);
		wr(FCS_STATUS_ADDR, 32'h0);
		rd(FCS_STATUS_ADDR, 33'ha0);
		chk(n_launch, 33'h0);
		wr(FCS_STATUS_ADDR, 32'h20);
		rd(FCS_STATUS_ADDR, 33'h80);
		wr(FCS_STATUS_ADDR, 32'h80);
		ctl_in.busy <= 1'b1;
		wr(FCS_STATUS_ADDR, 32'h0b);
		rd(FCS_STATUS_ADDR, 33'h08);
		chk(n_launch, 33'h1);
		mg = 2'($urandom);
		pulse({4'b1100, mg});
		rd(FCS_STATUS_ADDR, {25'h0, 6'h20, mg});
		// Interrupt: raise, mask, clear
		wr(FCS_CONFIG_ADDR, 32'h80);
		rd(FCS_CONFIG_ADDR, 33'h80);
		chk({32'h0, irq}, 33'h1);
		wr(FCS_CONFIG_ADDR, 32'h0);
		rd(FCS_EVT_EN_ADDR, 33'h0);
		chk({32'h0, irq}, 33'h0);
		wr(FCS_EVT_EN_ADDR, 32'h1);
		// Earlier access error and a nonzero status stay latched too
		rd(FCS_EVT_STAT_ADDR, {29'h0, mg != 2'h0, 3'h3});
		chk({32'h0, irq}, 33'h1);
		wr(FCS_EVT_CLR_ADDR, 32'h1);
		rd(FCS_EVT_STAT_ADDR, {29'h0, mg != 2'h0, 3'h2});
		chk({32'h0, irq}, 33'h0);
		// Protection fault blocks launch and loading
		wr(FCS_CMDSEQ_ADDR, 32'h1);
		wr(FCS_STATUS_ADDR, 32'h80);
		rd(FCS_STATUS_ADDR, 33'h00);
		pulse(6'b000100);
		rd(FCS_STATUS_ADDR, 33'h90);
		wr(FCS_CMDSEQ_ADDR, 32'h1);
		wr(FCS_STATUS_ADDR, 32'h80);
		wr(FCS_STATUS_ADDR, 32'h0);
		rd(FCS_STATUS_ADDR, 33'h90);
		chk(n_launch, 33'h2);
		chk(n_seq, 33'h2);
		rd(FCS_CMDSEQ_ADDR, 33'h0);
		wr(FCS_STATUS_ADDR, 32'h10);
		rd(FCS_STATUS_ADDR, 33'h80);
		wr(FCS_STATUS_ADDR, 32'h80);
		rd(FCS_STATUS_ADDR, 33'ha0);
		wr(FCS_STATUS_ADDR, 32'h20);
		// Command error ends run with access error
		wr(FCS_CMDSEQ_ADDR, 32'h1);
		wr(FCS_STATUS_ADDR, 32'h80);
		pulse(6'b001000);
		rd(FCS_STATUS_ADDR, 33'ha0);
		chk(n_launch, 33'h3);
		chk(n_seq, 33'h3);
		wr(FCS_STATUS_ADDR, 32'h20);
		wr(FCS_CMDSEQ_ADDR, 32'h1);
		wr(FCS_STATUS_ADDR, 32'h80);
		rst(1'b0);
		rd(FCS_STATUS_ADDR, 33'h80);
		conclude();
	end
endmodule : fcs_tb_top

`default_nettype wire
